/* common/hamc_defs.svh */
// register offsets, field positions and reset values of the amplifier mode control
`ifndef HAMC_DEFS_SVH
`define HAMC_DEFS_SVH

// ************************************************************
// register offsets
// ************************************************************
`define HAMC_AMP_CONTROL_ADDR 8'h01
`define HAMC_VOLUME_ADDR 8'h02
`define HAMC_OUTPUT_FLOAT_ADDR 8'h03
`define HAMC_FAULT_STATUS_ADDR 8'h04

// ************************************************************
// field positions
// ************************************************************
`define HAMC_LEFT_EN_BIT 7
`define HAMC_RIGHT_EN_BIT 6
`define HAMC_MODE_HI_BIT 5
`define HAMC_MODE_LO_BIT 4
`define HAMC_SOFT_DOWN_BIT 0
`define HAMC_LEFT_MUTE_BIT 7
`define HAMC_RIGHT_MUTE_BIT 6
`define HAMC_GAIN_HI_BIT 5
`define HAMC_LEFT_FLOAT_BIT 0
`define HAMC_RIGHT_FLOAT_BIT 1
`define HAMC_FAULT_BIT 0

// ************************************************************
// reset values and mode codes
// ************************************************************
`define HAMC_AMP_CONTROL_RST 8'h00
`define HAMC_VOLUME_RST 8'hC0
`define HAMC_OUTPUT_FLOAT_RST 8'h00
`define HAMC_MODE_STEREO 2'h0
`define HAMC_MODE_DUAL_MONO 2'h1
`define HAMC_MODE_BRIDGE 2'h2

`endif

/* common/hamc_pkg.sv */
// types shared by the amplifier mode control and its serial slave
package hamc_pkg;
  typedef logic [7:0] hamc_addr_t;
  typedef enum logic [2:0] {S_IDLE, S_ADDR, S_PTR, S_WRITE, S_READ} hamc_slave_state_t;
endpackage : hamc_pkg

/* src/hamc_serial_slave.sv */
// two-wire serial slave that turns bus writes into register write pulses
`timescale 1ns/1ps
`default_nettype none
module hamc_serial_slave #(
  parameter logic [6:0] DEV_ADDR = 7'h2C  // arbitrary value
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic scl_pin,
  input wire logic sda_pin,
  output logic sda_oe,
  output logic wr_pulse,
  output hamc_pkg::hamc_addr_t wr_addr,
  output logic [7:0] wr_data,
  output hamc_pkg::hamc_addr_t rd_addr,
  input wire logic [7:0] rd_data
);
  import hamc_pkg::*;

  logic scl_meta, scl_sync, scl_prev, sda_meta, sda_sync, sda_prev;
  hamc_slave_state_t state;
  logic [3:0] bit_cnt;
  logic [7:0] shreg;
  logic [7:0] ptr;
  logic ack_drive;
  logic read_req;
  logic start_cond, stop_cond, scl_rise, scl_fall;

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      scl_meta <= 1'b1;
      scl_sync <= 1'b1;
      scl_prev <= 1'b1;
      sda_meta <= 1'b1;
      sda_sync <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      scl_meta <= scl_pin;
      scl_sync <= scl_meta;
      scl_prev <= scl_sync;
      sda_meta <= sda_pin;
      sda_sync <= sda_meta;
      sda_prev <= sda_sync;
    end
  end

  assign start_cond = scl_sync && scl_prev && sda_prev && !sda_sync;
  assign stop_cond = scl_sync && scl_prev && !sda_prev && sda_sync;
  assign scl_rise = scl_sync && !scl_prev;
  assign scl_fall = !scl_sync && scl_prev;
  assign rd_addr = ptr;
  assign sda_oe = ack_drive || (state == S_READ && bit_cnt < 4'd8 && !shreg[7]);

  // ************************************************************
  // byte engine
  // ************************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      state <= S_IDLE;
      bit_cnt <= 4'h0;
      shreg <= 8'h00;
      ptr <= 8'h00;
      ack_drive <= 1'b0;
      read_req <= 1'b0;
      wr_pulse <= 1'b0;
      wr_addr <= 8'h00;
      wr_data <= 8'h00;
    end else begin
      wr_pulse <= 1'b0;
      if (start_cond) begin
        state <= S_ADDR;
        // the start's own scl fall wraps the count to zero
        bit_cnt <= 4'hF;
        ack_drive <= 1'b0;
      end else if (stop_cond) begin
        state <= S_IDLE;
        bit_cnt <= 4'h0;
        ack_drive <= 1'b0;
      end else if (state != S_IDLE && scl_rise) begin
        if (bit_cnt < 4'd8) begin
          if (state != S_READ) begin
            shreg <= {shreg[6:0], sda_sync};
          end
        end else if (state == S_READ) begin
          // master nack ends the read, ack moves to the next register
          if (sda_sync) begin
            state <= S_IDLE;
          end else begin
            ptr <= ptr + 8'h01;
          end
        end
      end else if (state != S_IDLE && scl_fall) begin
        if (bit_cnt == 4'd8) begin
          bit_cnt <= 4'h0;
          ack_drive <= 1'b0;
          case (state)
            S_ADDR: begin
              if (!ack_drive) begin
                state <= S_IDLE;
              end else if (read_req) begin
                state <= S_READ;
                shreg <= rd_data;
              end else begin
                state <= S_PTR;
              end
            end
            S_PTR: begin
              ptr <= shreg;
              state <= S_WRITE;
            end
            S_WRITE: begin
              // commit only once the acknowledge bit is over
              wr_pulse <= 1'b1;
              wr_addr <= ptr;
              wr_data <= shreg;
              ptr <= ptr + 8'h01;
            end
            S_READ: shreg <= rd_data;
            default: state <= S_IDLE;
          endcase
        end else begin
          bit_cnt <= bit_cnt + 4'h1;
          if (state == S_READ) begin
            shreg <= {shreg[6:0], 1'b0};
          end
          if (bit_cnt == 4'd7) begin
            case (state)
              S_ADDR: begin
                if (shreg[7:1] == DEV_ADDR) begin
                  ack_drive <= 1'b1;
                  read_req <= shreg[0];
                end
              end
              S_PTR, S_WRITE: ack_drive <= 1'b1;
              default: ack_drive <= 1'b0;
            endcase
          end
        end
      end
    end
  end

  a_commit_after_ack: assert property (@(posedge clk) disable iff (rst)
    wr_pulse |-> $past(ack_drive) && !ack_drive && $past(scl_fall))
    else $error("register write committed outside the acknowledge end");
endmodule : hamc_serial_slave
`default_nettype wire

/* src/hamc_mode_control.sv */
// register bank and mode decoding of the headphone amplifier
`timescale 1ns/1ps
`default_nettype none
`include "hamc_defs.svh"

// Summary of operation
// - shutdown pin low overrides every mode
// - hardware shutdown restores all register defaults
// - soft power down stops pump and outputs
// - clearing soft power down resumes operation
// - soft power down clears both enables
// - enable bits switch each amplifier independently
// - disabled amplifiers leave charge pump running
// - float bits release each output independently
// - mode 00 drives independent stereo channels
// - mode 01 copies left to both when both enables are set
// - mode 10 bridges left across outputs when both enables are set
// - start-up defaults: muted, stereo, disabled
// - thermal fault shuts down, flag readable
// - volume gives 64 steps; both mutes attenuate
module hamc_mode_control #(
  parameter logic [6:0] DEV_ADDR = 7'h2C  // arbitrary value
) (
  input wire logic CLOCK,
  input wire logic RESET,
  input wire logic HW_SHUTDOWN_N,
  input wire logic SCL,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  input wire logic THERMAL_TRIP,
  output logic CHARGE_PUMP_ON,
  output logic LEFT_OUTPUT_EN,
  output logic RIGHT_OUTPUT_EN,
  output logic LEFT_OUTPUT_FLOAT,
  output logic RIGHT_OUTPUT_FLOAT,
  output logic RIGHT_FROM_LEFT,
  output logic BRIDGE_EN,
  output logic [5:0] GAIN_STEP,
  output logic LEFT_MUTE,
  output logic RIGHT_MUTE,
  output logic FULL_ATTEN,
  output logic THERMAL_FAULT
);
  import hamc_pkg::*;

  logic sd_meta, sd_sync, therm_meta, therm_sync;
  logic hw_reset, active, both_en, fault;
  logic wr_pulse;
  hamc_addr_t wr_addr, rd_addr;
  logic [7:0] wr_data, rd_data, next_amp_control;
  logic [7:0] amp_control, volume, output_float_control;
  logic [1:0] mode;

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      sd_meta <= 1'b0;
      sd_sync <= 1'b0;
      therm_meta <= 1'b0;
      therm_sync <= 1'b0;
    end else begin
      sd_meta <= HW_SHUTDOWN_N;
      sd_sync <= sd_meta;
      therm_meta <= THERMAL_TRIP;
      therm_sync <= therm_meta;
    end
  end

  assign hw_reset = RESET || !sd_sync;
  assign SDA_OUT = 1'b0;

  // ************************************************************
  // serial slave
  // ************************************************************
  hamc_serial_slave #(.DEV_ADDR(DEV_ADDR)) u_slave (
    .clk(CLOCK),
    .rst(hw_reset),
    .scl_pin(SCL),
    .sda_pin(SDA_IN),
    .sda_oe(SDA_OE),
    .wr_pulse(wr_pulse),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .rd_addr(rd_addr),
    .rd_data(rd_data)
  );

  // ************************************************************
  // register bank
  // ************************************************************
  always_comb begin
    next_amp_control = wr_data;
    if (wr_data[`HAMC_SOFT_DOWN_BIT]) begin
      next_amp_control[`HAMC_LEFT_EN_BIT] = 1'b0;
      next_amp_control[`HAMC_RIGHT_EN_BIT] = 1'b0;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (hw_reset) begin
      amp_control <= `HAMC_AMP_CONTROL_RST;
      volume <= `HAMC_VOLUME_RST;
      output_float_control <= `HAMC_OUTPUT_FLOAT_RST;
    end else if (wr_pulse) begin
      case (wr_addr)
        `HAMC_AMP_CONTROL_ADDR: amp_control <= next_amp_control;
        `HAMC_VOLUME_ADDR: volume <= wr_data;
        `HAMC_OUTPUT_FLOAT_ADDR: output_float_control <= wr_data;
        default: amp_control <= amp_control;
      endcase
    end
  end

  // sticky fault, write one to clear, a new trip wins over the clear
  always_ff @(posedge CLOCK) begin
    if (hw_reset) begin
      fault <= 1'b0;
    end else if (therm_sync) begin
      fault <= 1'b1;
    end else if (wr_pulse && wr_addr == `HAMC_FAULT_STATUS_ADDR && wr_data[`HAMC_FAULT_BIT]) begin
      fault <= 1'b0;
    end
  end

  always_comb begin
    case (rd_addr)
      `HAMC_AMP_CONTROL_ADDR: rd_data = amp_control;
      `HAMC_VOLUME_ADDR: rd_data = volume;
      `HAMC_OUTPUT_FLOAT_ADDR: rd_data = output_float_control;
      `HAMC_FAULT_STATUS_ADDR: rd_data = {7'h00, fault};
      default: rd_data = 8'h00;
    endcase
  end

  // ************************************************************
  // mode decoding
  // ************************************************************
  assign mode = amp_control[`HAMC_MODE_HI_BIT:`HAMC_MODE_LO_BIT];
  assign active = sd_sync && !amp_control[`HAMC_SOFT_DOWN_BIT] && !fault;
  assign both_en = amp_control[`HAMC_LEFT_EN_BIT] && amp_control[`HAMC_RIGHT_EN_BIT];

  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      CHARGE_PUMP_ON <= 1'b0;
      LEFT_OUTPUT_EN <= 1'b0;
      RIGHT_OUTPUT_EN <= 1'b0;
      LEFT_OUTPUT_FLOAT <= 1'b0;
      RIGHT_OUTPUT_FLOAT <= 1'b0;
      RIGHT_FROM_LEFT <= 1'b0;
      BRIDGE_EN <= 1'b0;
      GAIN_STEP <= 6'h00;
      LEFT_MUTE <= 1'b1;
      RIGHT_MUTE <= 1'b1;
      FULL_ATTEN <= 1'b1;
      THERMAL_FAULT <= 1'b0;
    end else begin
      // pump depends only on power state, not on the enables
      CHARGE_PUMP_ON <= active;
      LEFT_OUTPUT_EN <= active && amp_control[`HAMC_LEFT_EN_BIT];
      RIGHT_OUTPUT_EN <= active && amp_control[`HAMC_RIGHT_EN_BIT];
      LEFT_OUTPUT_FLOAT <= sd_sync && output_float_control[`HAMC_LEFT_FLOAT_BIT];
      RIGHT_OUTPUT_FLOAT <= sd_sync && output_float_control[`HAMC_RIGHT_FLOAT_BIT];
      // stereo when neither routing flag is set
      RIGHT_FROM_LEFT <= both_en && mode == `HAMC_MODE_DUAL_MONO;
      BRIDGE_EN <= both_en && mode == `HAMC_MODE_BRIDGE;
      GAIN_STEP <= volume[`HAMC_GAIN_HI_BIT:0];
      LEFT_MUTE <= volume[`HAMC_LEFT_MUTE_BIT];
      RIGHT_MUTE <= volume[`HAMC_RIGHT_MUTE_BIT];
      FULL_ATTEN <= volume[`HAMC_LEFT_MUTE_BIT] && volume[`HAMC_RIGHT_MUTE_BIT];
      THERMAL_FAULT <= fault;
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  sequence s_trip_held;
    therm_sync && sd_sync ##1 sd_sync;
  endsequence

  a_hw_off_wins: assert property (@(posedge CLOCK) disable iff (RESET)
    !sd_sync |=> !CHARGE_PUMP_ON && !LEFT_OUTPUT_EN && !RIGHT_OUTPUT_EN && !BRIDGE_EN)
    else $error("outputs active during hardware shutdown");
  a_hw_off_defaults: assert property (@(posedge CLOCK) disable iff (RESET)
    !sd_sync |=> amp_control == `HAMC_AMP_CONTROL_RST && volume == `HAMC_VOLUME_RST
      && output_float_control == `HAMC_OUTPUT_FLOAT_RST)
    else $error("registers kept through hardware shutdown");
  a_soft_down_off: assert property (@(posedge CLOCK) disable iff (RESET)
    amp_control[`HAMC_SOFT_DOWN_BIT] |=> !CHARGE_PUMP_ON && !LEFT_OUTPUT_EN && !RIGHT_OUTPUT_EN)
    else $error("pump or outputs on in soft power down");
  a_soft_wake: assert property (@(posedge CLOCK) disable iff (RESET)
    $fell(amp_control[`HAMC_SOFT_DOWN_BIT]) && sd_sync && !fault |=> CHARGE_PUMP_ON)
    else $error("no wake after soft power down cleared");
  a_soft_clears_en: assert property (@(posedge CLOCK) disable iff (RESET)
    amp_control[`HAMC_SOFT_DOWN_BIT] |-> amp_control[`HAMC_LEFT_EN_BIT:`HAMC_RIGHT_EN_BIT] == 2'h0)
    else $error("enables left set in soft power down");
  a_enable_follow: assert property (@(posedge CLOCK) disable iff (RESET)
    active |=> LEFT_OUTPUT_EN == $past(amp_control[`HAMC_LEFT_EN_BIT])
      && RIGHT_OUTPUT_EN == $past(amp_control[`HAMC_RIGHT_EN_BIT]))
    else $error("amplifier enable does not follow its bit");
  a_pump_kept: assert property (@(posedge CLOCK) disable iff (RESET)
    active && !both_en |=> CHARGE_PUMP_ON)
    else $error("pump stopped by disabled amplifiers");
  a_float_follow: assert property (@(posedge CLOCK) disable iff (RESET || !sd_sync)
    1'b1 |=> LEFT_OUTPUT_FLOAT == $past(output_float_control[`HAMC_LEFT_FLOAT_BIT])
      && RIGHT_OUTPUT_FLOAT == $past(output_float_control[`HAMC_RIGHT_FLOAT_BIT]))
    else $error("float output does not follow its bit");
  a_stereo_route: assert property (@(posedge CLOCK) disable iff (RESET)
    mode == `HAMC_MODE_STEREO |=> !RIGHT_FROM_LEFT && !BRIDGE_EN)
    else $error("routing active in stereo mode");
  a_mono_route: assert property (@(posedge CLOCK) disable iff (RESET)
    both_en && mode == `HAMC_MODE_DUAL_MONO |=> RIGHT_FROM_LEFT && !BRIDGE_EN)
    else $error("dual mono routing missing");
  a_bridge_route: assert property (@(posedge CLOCK) disable iff (RESET)
    both_en && mode == `HAMC_MODE_BRIDGE |=> BRIDGE_EN && !RIGHT_FROM_LEFT)
    else $error("bridge routing missing");
  a_start_defaults: assert property (@(posedge CLOCK)
    RESET |=> volume == `HAMC_VOLUME_RST && amp_control == `HAMC_AMP_CONTROL_RST)
    else $error("start-up defaults wrong");
  a_thermal_down: assert property (@(posedge CLOCK) disable iff (RESET)
    s_trip_held |=> THERMAL_FAULT && !CHARGE_PUMP_ON)
    else $error("thermal trip did not shut down");
  a_mute_atten: assert property (@(posedge CLOCK) disable iff (RESET)
    volume[`HAMC_LEFT_MUTE_BIT] && volume[`HAMC_RIGHT_MUTE_BIT] |=> FULL_ATTEN)
    else $error("both mutes without full attenuation");
endmodule : hamc_mode_control
`default_nettype wire

/* sim/hamc_host_model.sv */
// two-wire bus master model that drives register transfers into the amplifier
`timescale 1ns/1ps
`default_nettype none
module hamc_host_model #(
  parameter logic [6:0] DEV_ADDR = 7'h2C  // arbitrary value
) (
  input wire logic clk,
  input wire logic dut_oe,
  output logic scl,
  output logic sda
);
  logic m_oe;
  // open drain wire with pull-up: released means high
  assign sda = ~(m_oe | dut_oe);
  initial begin
    scl = 1'b1;
    m_oe = 1'b0;
  end
  task automatic w(input int n);
    repeat (n) @(posedge clk);
  endtask : w
  // 100 clocks per bit keeps the bus at 400 kHz, low 1.5 us, high 1 us
  task automatic put(input logic b);
    m_oe <= ~b;
    w(30);
    scl <= 1'b1;
    w(40);
    scl <= 1'b0;
    w(30);
  endtask : put
  task automatic get(output logic b);
    m_oe <= 1'b0;
    w(30);
    scl <= 1'b1;
    w(20);
    b = sda;
    w(20);
    scl <= 1'b0;
    w(30);
  endtask : get
  task automatic start();
    m_oe <= 1'b0;
    w(30);
    scl <= 1'b1;
    w(30);
    m_oe <= 1'b1;
    w(30);
    scl <= 1'b0;
    w(30);
  endtask : start
  task automatic stop();
    m_oe <= 1'b1;
    w(30);
    scl <= 1'b1;
    w(30);
    m_oe <= 1'b0;
    w(60);
  endtask : stop
  task automatic wbyte(input logic [7:0] b, inout logic ok);
    logic a;
    for (int i = 7; i >= 0; i--) begin
      put(b[i]);
    end
    get(a);
    ok = ok & ~a;
  endtask : wbyte
  // always ends with a nack: one register per read
  task automatic rbyte(output logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      get(b[i]);
    end
    put(1'b1);
  endtask : rbyte
  // a full register value is always sent, never a single bit
  task automatic write(input logic [6:0] dev, input logic [7:0] p, input logic [7:0] d,
                       output logic ok);
    ok = 1'b1;
    start();
    wbyte({dev, 1'b0}, ok);
    wbyte(p, ok);
    wbyte(d, ok);
    stop();
  endtask : write
  task automatic read(input logic [7:0] p, output logic [7:0] d, output logic ok);
    ok = 1'b1;
    start();
    wbyte({DEV_ADDR, 1'b0}, ok);
    wbyte(p, ok);
    start();
    wbyte({DEV_ADDR, 1'b1}, ok);
    rbyte(d);
    stop();
  endtask : read
endmodule : hamc_host_model
`default_nettype wire

/* sim/testbench.sv */
// self-checking bench of the amplifier mode control
`timescale 1ns/1ps
`default_nettype none
`include "hamc_defs.svh"
module testbench;
  localparam logic [6:0] DEV = 7'h2C;  // arbitrary value
  logic CLOCK, RESET, HW_SHUTDOWN_N, THERMAL_TRIP, scl, sda, sda_oe, sda_out, ok;
  logic pump, l_en, r_en, l_fl, r_fl, rfl, br, l_mu, r_mu, att, fault;
  logic [5:0] gain;
  logic [7:0] rd, v, vol;
  logic [31:0] seed;
  logic [7:0] corner [4] = '{8'hC0, 8'hD0, 8'hE0, 8'h80};
  int bad_count, checked;
  hamc_mode_control #(.DEV_ADDR(DEV)) i_dut (.CLOCK(CLOCK), .RESET(RESET),
    .HW_SHUTDOWN_N(HW_SHUTDOWN_N), .SCL(scl), .SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE(sda_oe),
    .THERMAL_TRIP(THERMAL_TRIP), .CHARGE_PUMP_ON(pump), .LEFT_OUTPUT_EN(l_en),
    .RIGHT_OUTPUT_EN(r_en), .LEFT_OUTPUT_FLOAT(l_fl), .RIGHT_OUTPUT_FLOAT(r_fl),
    .RIGHT_FROM_LEFT(rfl), .BRIDGE_EN(br), .GAIN_STEP(gain), .LEFT_MUTE(l_mu),
    .RIGHT_MUTE(r_mu), .FULL_ATTEN(att), .THERMAL_FAULT(fault));
  hamc_host_model #(.DEV_ADDR(DEV)) i_host (.clk(CLOCK), .dut_oe(sda_oe), .scl(scl),
    .sda(sda));
  initial begin
    CLOCK = 1'b0;
    forever #12.5 CLOCK = ~CLOCK;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  // expected {pump, left, right, mono copy, bridge} for an amp_control value
  function automatic logic [4:0] exp_amp(input logic [7:0] c);
    logic l, r;
    l = c[7] & ~c[0];
    r = c[6] & ~c[0];
    return {~c[0], l, r, l & r & (c[5:4] == 2'h1), l & r & (c[5:4] == 2'h2)};
  endfunction : exp_amp
  function automatic logic [7:0] outs();
    return {2'h0, fault, pump, l_en, r_en, rfl, br};
  endfunction : outs
  task automatic test_done();
    if (bad_count == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : test_done
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    #1;
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    i_host.write(DEV, p, d, ok);
    chk({7'h0, ok}, 8'h01);
  endtask : wr
  task automatic rdc(input logic [7:0] p, input logic [7:0] exp);
    i_host.read(p, rd, ok);
    chk(ok ? rd : ~exp, exp);
  endtask : rdc
  initial begin
    repeat (98000) @(posedge CLOCK);
    bad_count++;
    test_done();
  end
  initial begin
    RESET = 1'b1;
    HW_SHUTDOWN_N = 1'b1;
    THERMAL_TRIP = 1'b0;
    seed = 32'hA640B2C2;
    bad_count = 0;
    checked = 0;
    repeat (10) @(posedge CLOCK);
    RESET <= 1'b0;
    repeat (6) @(posedge CLOCK);
    chk(outs(), 8'h10);
    chk({2'h0, l_mu, r_mu, att, l_fl, r_fl, sda_out}, 8'h38);
    rdc(`HAMC_OUTPUT_FLOAT_ADDR, 8'h00);
    // corner modes first, then random values with the low nibble cleared
    for (int i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      v = (i < 4) ? corner[i] : seed[7:0] & 8'hF0;
      wr(`HAMC_AMP_CONTROL_ADDR, v);
      chk(outs(), {3'h0, exp_amp(v)});
      seed = lfsr(seed);
      vol = (i == 0) ? 8'hFF : (i == 1) ? 8'h3F : seed[7:0];
      wr(`HAMC_VOLUME_ADDR, vol);
      chk({l_mu, r_mu, gain}, vol);
      chk({7'h0, att}, {7'h0, vol[7] & vol[6]});
    end
    wr(`HAMC_AMP_CONTROL_ADDR, 8'hD1);
    chk(outs(), 8'h00);
    rdc(`HAMC_AMP_CONTROL_ADDR, 8'h11);
    rdc(`HAMC_VOLUME_ADDR, vol);
    wr(`HAMC_AMP_CONTROL_ADDR, 8'hD0);
    chk(outs(), {3'h0, exp_amp(8'hD0)});
    // floats only requested with both amplifiers disabled
    wr(`HAMC_AMP_CONTROL_ADDR, 8'h00);
    for (int f = 1; f < 5; f++) begin
      wr(`HAMC_OUTPUT_FLOAT_ADDR, f[7:0] & 8'h03);
      chk({6'h0, r_fl, l_fl}, f[7:0] & 8'h03);
    end
    i_host.write(DEV ^ 7'h01, `HAMC_AMP_CONTROL_ADDR, 8'hC0, ok);
    chk({7'h0, ok}, 8'h00);
    ok = 1'b1;
    i_host.start();
    i_host.wbyte({DEV, 1'b0}, ok);
    i_host.wbyte(`HAMC_AMP_CONTROL_ADDR, ok);
    for (int b = 0; b < 4; b++) begin
      i_host.put(1'b1);
    end
    i_host.stop();
    chk(outs(), 8'h10);
    wr(`HAMC_AMP_CONTROL_ADDR, 8'hC0);
    @(posedge CLOCK);
    THERMAL_TRIP <= 1'b1;
    repeat (8) @(posedge CLOCK);
    chk(outs(), 8'h20);
    @(posedge CLOCK);
    THERMAL_TRIP <= 1'b0;
    rdc(`HAMC_FAULT_STATUS_ADDR, 8'h01);
    wr(`HAMC_FAULT_STATUS_ADDR, 8'h01);
    chk(outs(), {3'h0, exp_amp(8'hC0)});
    wr(`HAMC_VOLUME_ADDR, 8'h25);
    @(posedge CLOCK);
    HW_SHUTDOWN_N <= 1'b0;
    repeat (6) @(posedge CLOCK);
    chk(outs(), 8'h00);
    chk({5'h0, l_mu, r_mu, att}, 8'h07);
    @(posedge CLOCK);
    HW_SHUTDOWN_N <= 1'b1;
    repeat (6) @(posedge CLOCK);
    chk(outs(), 8'h10);
    rdc(`HAMC_AMP_CONTROL_ADDR, 8'h00);
    rdc(`HAMC_VOLUME_ADDR, 8'hC0);
    test_done();
  end
endmodule : testbench
`default_nettype wire
